// ===== hdl/kwu_pkg.sv
// Notes on behaviour
// [RULE1] Each key pin enabled by own bit
// [RULE2] Enables bits 7..4 at 0F88H, reset zero
// [RULE3] Enable bits are write-only, read zero
// [RULE4] Enabled low key pin releases stop mode
// [RULE5] Software checks enabled pins high first
// [RULE6] Release condition at entry skips stop, warms up
// [RULE7] Edge mode: key pins disabled or held high
// [RULE8] Dedicated release pin always a source
// [RULE9] Dedicated pin held low for key release
// [RULE10] Level mode: pin high/keys low; edge: rising
// [RULE11] Software sets key port pins as inputs
// [RULE12] Software disables analog input on key pins
// [RULE13] Dedicated pin shared with interrupt five releases
// [RULE14] Key request is OR of enable and low pin
`default_nettype none
package kwu_pkg;
	localparam logic [11:0] KWU_ENABLE_OFFS = 12'hf88; // Enable register
	localparam int KWU_EN_LSB = 4; // Key pin 0 enable position
	localparam int KWU_KEYS = 4; // Number of key pins
	localparam logic [3:0] KWU_EN_RESET = 4'h0; // Enables after reset
	localparam logic [7:0] KWU_READ_ZERO = 8'h00; // Read answer
	typedef enum {KWU_RUN, KWU_STOPPED, KWU_WARMUP} kwu_state_e;
endpackage : kwu_pkg
`default_nettype wire

// ===== hdl/kwu_sync.sv
`default_nettype none
// Two-flop synchroniser bank for asynchronous pins
module kwu_sync #(
	parameter int W = 5
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg; // First stage, read only by second
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;
	// Next values: plain shift
	always_comb begin
		meta_next = d_i;
		q_next = meta_reg;
	end
	// Pins idle high after reset so no false wake is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '1;
			q_o <= '1;
		end else if (ce_i) begin
			meta_reg <= meta_next;
			q_o <= q_next;
		end
	end
endmodule : kwu_sync
`default_nettype wire

// ===== hdl/kwu_top.sv
`default_nettype none
// Key-on wakeup control. The request gates the enables with the synchronised
// pins, so it follows the pins only while the clock runs.
// Limitation: the release check sees the pins through the two-flop
// synchroniser, so a clocked model of stop adds two cycles of latency.
// The dedicated release pin idles low and the key pins idle high; the
// synchroniser must come out of reset at each pin's idle level.
module kwu_top (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic [11:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic [3:0] KEY_WAKE_PIN_I,
	input wire logic STOP_RELEASE_PIN_I,
	input wire logic STOP_ENTRY_I,
	input wire logic RELEASE_LEVEL_MODE_I,
	output logic KEY_WAKE_REQ_O,
	output logic STOP_MODE_O,
	output logic WARMUP_START_O
);
	logic [3:0] en_reg; // Key pin enables
	logic [3:0] en_next;
	logic [3:0] key_s; // Synchronised key pins
	logic rel_s; // Synchronised dedicated pin
	logic rel_n_s; // Same pin, inverted through the synchroniser
	logic rel_d_reg; // Previous dedicated pin level
	logic rel_d_next;
	logic [7:0] rdata_next;
	logic rel_cond; // Any release condition present
	logic rel_edge;
	kwu_pkg::kwu_state_e st_reg, st_next;

	// Address decode used by write path
	function automatic logic hit(input logic [11:0] a);
		hit = (a == kwu_pkg::KWU_ENABLE_OFFS);
	endfunction : hit

	kwu_sync #(.W(5)) u_sync (
		.clk_i(REF_CLK_I),
		.ce_i(CE_I),
		.rst_i(RST_I),
		// Dedicated pin goes through inverted: the bank resets high, which
		// must read as this pin's idle low, else a false edge follows reset
		.d_i({~STOP_RELEASE_PIN_I, KEY_WAKE_PIN_I}),
		.q_o({rel_n_s, key_s})
	);

	// Undo the inversion of the dedicated pin
	always_comb begin
		rel_s = ~rel_n_s; // RULE13
	end

	// Key request: AND-OR of enable and inverted pin
	always_comb begin
		KEY_WAKE_REQ_O = |(en_reg & ~key_s); // RULE14 RULE4 RULE1
	end

	// Release condition: level mode uses levels, edge mode the dedicated pin's rising edge plus key levels
	always_comb begin
		rel_edge = rel_s & ~rel_d_reg; // RULE10
		if (RELEASE_LEVEL_MODE_I) begin
			rel_cond = rel_s | KEY_WAKE_REQ_O; // RULE10 RULE13 RULE8
		end else begin
			// Keys still gate in edge mode; software must keep them idle
			rel_cond = rel_edge | KEY_WAKE_REQ_O; // RULE13
		end
	end

	// Register writes; reads always give zero since enables are write-only
	always_comb begin
		en_next = en_reg;
		rdata_next = kwu_pkg::KWU_READ_ZERO; // RULE3
		rel_d_next = rel_s;
		if (WR_I && hit(ADDR_I)) begin
			en_next = WDATA_I[kwu_pkg::KWU_EN_LSB +: 4]; // RULE2
		end
	end

	// Stop sequencing; entry is refused when release already pending
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			kwu_pkg::KWU_RUN: begin
				if (STOP_ENTRY_I) begin
					// Entry check uses levels in both modes
					if (rel_s || KEY_WAKE_REQ_O) begin
						st_next = kwu_pkg::KWU_WARMUP; // RULE6
					end else begin
						st_next = kwu_pkg::KWU_STOPPED;
					end
				end
			end
			kwu_pkg::KWU_STOPPED: begin
				if (rel_cond) begin
					st_next = kwu_pkg::KWU_WARMUP; // RULE4
				end
			end
			kwu_pkg::KWU_WARMUP: begin
				// Warm-up is handed off to the clock generator
				st_next = kwu_pkg::KWU_RUN;
			end
		endcase
	end

	// Outputs follow state
	always_comb begin
		STOP_MODE_O = (st_reg == kwu_pkg::KWU_STOPPED);
		WARMUP_START_O = (st_reg == kwu_pkg::KWU_WARMUP);
	end

	// State registers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			en_reg <= kwu_pkg::KWU_EN_RESET; // RULE2
			RDATA_O <= kwu_pkg::KWU_READ_ZERO;
			rel_d_reg <= 1'b0;
			st_reg <= kwu_pkg::KWU_RUN;
		end else if (CE_I) begin
			en_reg <= en_next;
			RDATA_O <= rdata_next;
			rel_d_reg <= rel_d_next;
			st_reg <= st_next;
		end
	end

	// Checks below watch only what this block drives. Cycles frozen by
	// the clock enable are left out of the antecedents, since state is
	// not meant to move on them; only a_freeze takes them, to check that.

	// A write to the enable register lands on the next edge
	a_enable_write: assert property (@(posedge REF_CLK_I) // RULE2
		disable iff (RST_I)
		CE_I && WR_I && hit(ADDR_I)
		|=> en_reg == $past(WDATA_I[kwu_pkg::KWU_EN_LSB +: 4]))
		else $error("enable write lost");

	// Reset clears every enable and returns to run
	a_reset_clear: assert property (@(posedge REF_CLK_I) // RULE2
		RST_I
		|=> en_reg == kwu_pkg::KWU_EN_RESET && st_reg == kwu_pkg::KWU_RUN)
		else $error("reset state wrong");

	// Enables never show on the read port
	a_read_zero: assert property (@(posedge REF_CLK_I) // RULE3
		disable iff (RST_I)
		RDATA_O == kwu_pkg::KWU_READ_ZERO)
		else $error("enable readable");

	// Request is the AND-OR of enables and low pins
	a_key_req: assert property (@(posedge REF_CLK_I) // RULE14
		disable iff (RST_I)
		KEY_WAKE_REQ_O == |(en_reg & ~key_s))
		else $error("key request wrong");

	// An enabled low key ends stop on the next edge
	a_key_wake: assert property (@(posedge REF_CLK_I) // RULE4
		disable iff (RST_I)
		CE_I && STOP_MODE_O && KEY_WAKE_REQ_O |=> WARMUP_START_O)
		else $error("no key wake");

	// Without a release condition stop holds
	a_stop_hold: assert property (@(posedge REF_CLK_I) // RULE4
		disable iff (RST_I)
		CE_I && STOP_MODE_O && !rel_cond |=> STOP_MODE_O)
		else $error("stop left without cause");

	// Entry with a release pending goes straight to warm-up
	a_entry_skip: assert property (@(posedge REF_CLK_I) // RULE6
		disable iff (RST_I)
		CE_I && st_reg == kwu_pkg::KWU_RUN && STOP_ENTRY_I
		&& (rel_s || KEY_WAKE_REQ_O) |=> WARMUP_START_O)
		else $error("stop entered despite release");

	// Entry with nothing pending does reach stop
	a_entry_clean: assert property (@(posedge REF_CLK_I) // RULE6
		disable iff (RST_I)
		CE_I && st_reg == kwu_pkg::KWU_RUN && STOP_ENTRY_I
		&& !rel_s && !KEY_WAKE_REQ_O |=> STOP_MODE_O)
		else $error("stop entry lost");

	// Level mode: a high dedicated pin releases
	a_level_pin: assert property (@(posedge REF_CLK_I) // RULE10
		disable iff (RST_I)
		CE_I && STOP_MODE_O && RELEASE_LEVEL_MODE_I && rel_s
		|=> !STOP_MODE_O)
		else $error("level release missed");

	// Edge mode: a rising edge of the dedicated pin releases
	a_edge_pin: assert property (@(posedge REF_CLK_I) // RULE10 RULE13
		disable iff (RST_I)
		CE_I && STOP_MODE_O && !RELEASE_LEVEL_MODE_I && rel_s && !rel_d_reg
		|=> WARMUP_START_O)
		else $error("edge release missed");

	// Warm-up start is a single-cycle hand-off
	a_warm_short: assert property (@(posedge REF_CLK_I) // RULE6
		disable iff (RST_I)
		CE_I && WARMUP_START_O |=> !WARMUP_START_O)
		else $error("warmup stuck");

	// A low clock enable freezes enables and sequencing
	a_freeze: assert property (@(posedge REF_CLK_I) // RULE2
		disable iff (RST_I)
		!CE_I |=> $stable(en_reg) && $stable(st_reg))
		else $error("state moved while frozen");

	// Main scenarios
	c_key_wake: cover property (@(posedge REF_CLK_I)
		STOP_MODE_O ##1 WARMUP_START_O);
	c_skip: cover property (@(posedge REF_CLK_I)
		STOP_ENTRY_I && KEY_WAKE_REQ_O);
	c_write: cover property (@(posedge REF_CLK_I) WR_I && hit(ADDR_I));
	c_read: cover property (@(posedge REF_CLK_I) RD_I && hit(ADDR_I));
endmodule : kwu_top
`default_nettype wire

// ===== tb/kwu_keys.sv
`default_nettype none
// Key switches with pull-ups, plus the dedicated release line
module kwu_keys (
	input wire logic [3:0] press_i,
	input wire logic rel_i,
	output logic [3:0] pin_o,
	output logic rel_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-ups: a released key reads high, so idle pins never wake
	assign pin_o = ~press_i;
	// Release line held low unless a test drives it high
	assign rel_o = rel_i;
endmodule : kwu_keys
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, wr = 0, rd = 0, se = 0, mode = 1, rel = 0;
	logic look = 0;
	logic ce = 1; // Clock enable
	logic [11:0] addr = '0;
	logic [7:0] wd = '0, rdo;
	logic [3:0] press = '0, pins;
	logic rel_p, req, stp, wu;
	logic [10:0] q[$]; // Expected {rdata, stop, warmup, request}
	int bad_count = 0, check_count = 0, cyc = 0;
	// 20 MHz clock
	always #25 clk = ~clk;
	kwu_keys keys (.press_i(press), .rel_i(rel), .pin_o(pins),
		.rel_o(rel_p));
	kwu_top uut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr),
		.WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdo),
		.KEY_WAKE_PIN_I(pins), .STOP_RELEASE_PIN_I(rel_p),
		.STOP_ENTRY_I(se), .RELEASE_LEVEL_MODE_I(mode),
		.KEY_WAKE_REQ_O(req), .STOP_MODE_O(stp), .WARMUP_START_O(wu));
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	// Note what the outputs must show after n more edges
	task ex(input logic [2:0] e, input int n);
		repeat (n) @(posedge clk);
		q.push_back({8'h00, e});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask : ex
	task wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [11:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	task stop_in;
		@(posedge clk);
		se <= 1'b1;
		@(posedge clk);
		se <= 1'b0;
	endtask : stop_in
	// Watcher: compares the oldest note with the outputs
	always @(posedge clk) begin : mon
		logic [10:0] e;
		if (look) begin
			e = q.pop_front();
			check_count++;
			if ({rdo, stp, wu, req} !== e) begin
				bad_count++;
				$display("mismatch outs exp %h got %h", e, {rdo, stp, wu, req});
			end
		end
	end
	// Hang guard, far above the 126 or so cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(30));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		press <= 4'hf;
		ex(3'b000, 3);
		rd_reg(kwu_pkg::KWU_ENABLE_OFFS);
		ex(3'b000, 0);
		for (int i = 0; i < 4; i++) begin
			press <= ~(4'h1 << i);
			wr_reg(kwu_pkg::KWU_ENABLE_OFFS, 8'h10 << i);
			rd_reg(kwu_pkg::KWU_ENABLE_OFFS);
			ex(3'b000, 0);
			wr_reg(12'hf89, 8'($urandom));
			ex(3'b000, 2);
			stop_in;
			ex(3'b100, 0);
			press <= 4'hf;
			ex(3'b101, 2);
			ex(3'b011, 0);
			stop_in;
			ex(3'b011, 0);
			$display("key %0d done", i);
		end
		// Frozen by the clock enable: this write must not land
		ce <= 1'b0;
		wr_reg(kwu_pkg::KWU_ENABLE_OFFS, 8'h00);
		ce <= 1'b1;
		ex(3'b001, 0);
		$display("freeze done");
		press <= 4'h0;
		for (int m = 1; m >= 0; m--) begin
			mode <= m[0];
			rel <= 1'b0;
			ex(3'b000, 2);
			stop_in;
			ex(3'b100, 0);
			rel <= 1'b1;
			ex(3'b100, 2);
			ex(3'b010, 0);
			stop_in;
			ex(3'b010, 0);
			$display("mode %0d done", m);
		end
		finish_test();
	end
endmodule : tb
`default_nettype wire
